// file: rtl/mms_consts.vh
// constants for the measurement mode sequencer
// assumes a 10 MHz clock and a classic wishbone register bus
`ifndef MMS_CONSTS_VH
`define MMS_CONSTS_VH

// ========================================
// register map (byte addresses)
`define MMS_ADDR_W        8
`define MMS_REG_ID        8'hD0
`define MMS_REG_STATUS    8'hF3
`define MMS_REG_MEAS      8'hF4
`define MMS_REG_CONF      8'hF5
`define MMS_REG_PRES      8'hF8
`define MMS_REG_TEMP      8'hFC

// ========================================
// fields
`define MMS_MODE_LSB      0
`define MMS_MODE_MSB      1
`define MMS_OSP_LSB       2
`define MMS_OSP_MSB       4
`define MMS_OST_LSB       5
`define MMS_OST_MSB       7
`define MMS_FLT_LSB       2
`define MMS_FLT_MSB       4
`define MMS_TSB_LSB       5
`define MMS_TSB_MSB       7
`define MMS_MODE_SLEEP    2'h0
`define MMS_MODE_NORMAL   2'h3
`define MMS_OS_SKIP       3'h0
`define MMS_MEAS_RST      8'h00
`define MMS_CONF_RST      8'h00
`define MMS_SKIP_VAL      20'h80000
`define MMS_ZERO8         8'h00
`define MMS_ZERO20        20'h00000

// ========================================
// timing: 10 MHz clock, standby figures in microseconds
`define MMS_CLK_KHZ       10000
`define MMS_TSB0_US       500
`define MMS_TSB1_US       62500
`define MMS_TSB2_US       125000
`define MMS_TSB3_US       250000
`define MMS_TSB4_US       500000
`define MMS_TSB5_US       1000000
`define MMS_TSB6_US       2000000
`define MMS_TSB7_US       4000000
`define MMS_US_TO_CYC(u)  (((u) * (`MMS_CLK_KHZ / 1000)))
`define MMS_CNT_W         26
`define MMS_MEAS_US       5500

`endif

// file: rtl/mms_sequencer.v
// power-mode and measurement sequencer with wishbone register slave
// assumes synchronous inputs, sample data presented by an external converter
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
`include "mms_consts.vh"

module mms_sequencer #(
  parameter [7:0]            PART_IDENTITY = 8'h5A, // arbitrary value
  parameter [`MMS_CNT_W-1:0] MEAS_CYC      = `MMS_US_TO_CYC(`MMS_MEAS_US),
  parameter [`MMS_CNT_W-1:0] TSB0_CYC      = `MMS_US_TO_CYC(`MMS_TSB0_US),
  parameter [`MMS_CNT_W-1:0] TSB1_CYC      = `MMS_US_TO_CYC(`MMS_TSB1_US),
  parameter [`MMS_CNT_W-1:0] TSB2_CYC      = `MMS_US_TO_CYC(`MMS_TSB2_US),
  parameter [`MMS_CNT_W-1:0] TSB3_CYC      = `MMS_US_TO_CYC(`MMS_TSB3_US),
  parameter [`MMS_CNT_W-1:0] TSB4_CYC      = `MMS_US_TO_CYC(`MMS_TSB4_US),
  parameter [`MMS_CNT_W-1:0] TSB5_CYC      = `MMS_US_TO_CYC(`MMS_TSB5_US),
  parameter [`MMS_CNT_W-1:0] TSB6_CYC      = `MMS_US_TO_CYC(`MMS_TSB6_US),
  parameter [`MMS_CNT_W-1:0] TSB7_CYC      = `MMS_US_TO_CYC(`MMS_TSB7_US)
) (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  // wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [7:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // converter samples
  input  wire [19:0] raw_pres_i,
  input  wire [19:0] raw_temp_i,
  // sequencer state
  output wire        measuring_o,
  output wire        standby_o
);

  // ========================================
  // states
  localparam [1:0] ST_SLEEP = 2'd0;
  localparam [1:0] ST_MEAS  = 2'd1;
  localparam [1:0] ST_STBY  = 2'd2;

  reg  [1:0]            state_r;
  reg  [7:0]            meas_ctl_r;
  reg  [7:0]            conf_ctl_r;
  reg  [1:0]            pend_mode_r;
  reg                   pend_r;
  reg                   forced_run_r;
  reg  [`MMS_CNT_W-1:0] cnt_r;
  reg  [19:0]           pres_out_r;
  reg  [19:0]           temp_out_r;
  reg  [19:0]           pres_flt_r;
  reg  [19:0]           temp_flt_r;
  reg                   flt_init_r;
  reg  [`MMS_CNT_W-1:0] tsb_cyc;

  wire       wr_en   = cyc_i & stb_i & we_i & ~ack_o & sel_i[0];
  wire       rd_en   = cyc_i & stb_i & ~ack_o;
  wire [1:0] mode_f  = meas_ctl_r[`MMS_MODE_MSB:`MMS_MODE_LSB];
  wire [2:0] osp_f   = meas_ctl_r[`MMS_OSP_MSB:`MMS_OSP_LSB];
  wire [2:0] ost_f   = meas_ctl_r[`MMS_OST_MSB:`MMS_OST_LSB];
  wire [2:0] flt_f   = conf_ctl_r[`MMS_FLT_MSB:`MMS_FLT_LSB];
  wire [1:0] wr_mode = dat_i[`MMS_MODE_MSB:`MMS_MODE_LSB];
  wire       wr_meas = wr_en & (adr_i == `MMS_REG_MEAS);
  wire       wr_conf = wr_en & (adr_i == `MMS_REG_CONF);
  wire       meas_done = (state_r == ST_MEAS) & (cnt_r == {`MMS_CNT_W{1'b0}});

  assign measuring_o = (state_r == ST_MEAS);
  assign standby_o   = (state_r == ST_STBY);

  // ========================================
  // standby length lookup
  always @* begin
    case (conf_ctl_r[`MMS_TSB_MSB:`MMS_TSB_LSB])
      3'h0:    tsb_cyc = TSB0_CYC;
      3'h1:    tsb_cyc = TSB1_CYC;
      3'h2:    tsb_cyc = TSB2_CYC;
      3'h3:    tsb_cyc = TSB3_CYC;
      3'h4:    tsb_cyc = TSB4_CYC;
      3'h5:    tsb_cyc = TSB5_CYC;
      3'h6:    tsb_cyc = TSB6_CYC;
      default: tsb_cyc = TSB7_CYC;
    endcase
  end

  // simple iir step: old*(k-1)+new over k, k = 2^code, code capped at 4
  function [19:0] iir_step;
    input [19:0] old_v;
    input [19:0] new_v;
    input [2:0]  code;
    reg   [24:0] acc;
    reg   [2:0]  sh;
    begin
      sh  = (code > 3'h4) ? 3'h4 : code;
      acc = ({5'h00, old_v} << sh) - {5'h00, old_v} + {5'h00, new_v};
      acc = acc >> sh;
      iir_step = acc[19:0];
    end
  endfunction

  // ========================================
  // registers and sequencer
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_r      <= ST_SLEEP;
      meas_ctl_r   <= `MMS_MEAS_RST;
      conf_ctl_r   <= `MMS_CONF_RST;
      pend_mode_r  <= `MMS_MODE_SLEEP;
      pend_r       <= 1'b0;
      forced_run_r <= 1'b0;
      cnt_r        <= {`MMS_CNT_W{1'b0}};
      pres_out_r   <= `MMS_SKIP_VAL;
      temp_out_r   <= `MMS_SKIP_VAL;
      pres_flt_r   <= `MMS_ZERO20;
      temp_flt_r   <= `MMS_ZERO20;
      flt_init_r   <= 1'b1;
      ack_o        <= 1'b0;
      dat_o        <= 32'h00000000;
    end else if (ce_i) begin
      ack_o <= rd_en;
      if (rd_en && !we_i) begin
        case (adr_i)
          `MMS_REG_ID:     dat_o <= {24'h000000, PART_IDENTITY};
          `MMS_REG_STATUS: dat_o <= {28'h0000000, pend_r, standby_o, 1'b0, measuring_o};
          `MMS_REG_MEAS:   dat_o <= {24'h000000, meas_ctl_r};
          `MMS_REG_CONF:   dat_o <= {24'h000000, conf_ctl_r};
          `MMS_REG_PRES:   dat_o <= {12'h000, pres_out_r};
          `MMS_REG_TEMP:   dat_o <= {12'h000, temp_out_r};
          default:         dat_o <= 32'h00000000;
        endcase
      end else if (rd_en) begin
        // writes answer with zeros so stale read data never looks fresh
        dat_o <= 32'h00000000;
      end
      if (wr_conf) begin
        conf_ctl_r <= dat_i[7:0];
        flt_init_r <= 1'b1;
      end
      if (wr_meas) begin
        meas_ctl_r[`MMS_OST_MSB:`MMS_OSP_LSB] <= dat_i[`MMS_OST_MSB:`MMS_OSP_LSB];
        if (state_r != ST_MEAS) begin
          meas_ctl_r[`MMS_MODE_MSB:`MMS_MODE_LSB] <= wr_mode;
        end else if (!pend_r) begin
          pend_r      <= 1'b1;
          pend_mode_r <= wr_mode;
        end
        // the mode field of further writes while pending is dropped; oversampling fields still update
      end
      case (state_r)
        ST_SLEEP: begin
          // no counting while asleep
          if (wr_meas && wr_mode != `MMS_MODE_SLEEP) begin
            state_r      <= ST_MEAS;
            cnt_r        <= MEAS_CYC;
            forced_run_r <= (wr_mode != `MMS_MODE_NORMAL);
          end
        end
        ST_MEAS: begin
          if (meas_done) begin
            // skipped channel keeps its memory
            if (osp_f == `MMS_OS_SKIP) begin
              pres_out_r <= `MMS_SKIP_VAL;
            end else begin
              pres_out_r <= flt_init_r ? raw_pres_i : iir_step(pres_flt_r, raw_pres_i, flt_f);
              pres_flt_r <= flt_init_r ? raw_pres_i : iir_step(pres_flt_r, raw_pres_i, flt_f);
            end
            if (ost_f == `MMS_OS_SKIP) begin
              temp_out_r <= `MMS_SKIP_VAL;
            end else begin
              temp_out_r <= flt_init_r ? raw_temp_i : iir_step(temp_flt_r, raw_temp_i, flt_f);
              temp_flt_r <= flt_init_r ? raw_temp_i : iir_step(temp_flt_r, raw_temp_i, flt_f);
            end
            if (!wr_conf) begin
              flt_init_r <= 1'b0;
            end
            pend_r <= 1'b0;
            if (pend_r) begin
              meas_ctl_r[`MMS_MODE_MSB:`MMS_MODE_LSB] <= pend_mode_r;
              if (pend_mode_r == `MMS_MODE_NORMAL) begin
                state_r      <= ST_STBY;
                cnt_r        <= tsb_cyc;
                forced_run_r <= 1'b0;
              end else if (pend_mode_r == `MMS_MODE_SLEEP) begin
                state_r <= ST_SLEEP;
              end else begin
                state_r      <= ST_MEAS;
                cnt_r        <= MEAS_CYC;
                forced_run_r <= 1'b1;
              end
            end else if (forced_run_r) begin
              state_r <= ST_SLEEP;
              meas_ctl_r[`MMS_MODE_MSB:`MMS_MODE_LSB] <= `MMS_MODE_SLEEP;
            end else begin
              state_r <= ST_STBY;
              cnt_r   <= tsb_cyc;
            end
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        ST_STBY: begin
          if (wr_meas && wr_mode != `MMS_MODE_NORMAL) begin
            // standby is not a measurement, change applies at once
            if (wr_mode == `MMS_MODE_SLEEP) begin
              state_r <= ST_SLEEP;
            end else begin
              state_r      <= ST_MEAS;
              cnt_r        <= MEAS_CYC;
              forced_run_r <= 1'b1;
            end
          end else if (cnt_r == {`MMS_CNT_W{1'b0}}) begin
            state_r <= ST_MEAS;
            cnt_r   <= MEAS_CYC;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        default: state_r <= ST_SLEEP;
      endcase
    end
  end

endmodule
`default_nettype wire

// file: dv/mms_conv_model.sv
// converter stand-in giving a fresh sample pair per measurement
// assumes the sequencer samples in the last measuring cycle
`timescale 1ns/10ps
`default_nettype none
module mms_conv_model (
  // clock and state
  input  wire logic        clk_i,
  input  wire logic        measuring_i,
  // samples
  output var  logic [19:0] pres_o,
  output var  logic [19:0] temp_o
);
  logic [19:0] n_r   = 20'h0;
  logic        was_r = 1'b0;
  // step one cycle after the end, so the sampled value is never in flux
  always @(posedge clk_i) begin
    was_r <= measuring_i;
    if (was_r && !measuring_i)
      n_r <= n_r + 20'h1;
  end
  assign pres_o = 20'h10000 + n_r;
  assign temp_o = 20'h20000 + n_r;
endmodule
`default_nettype wire

// file: dv/mms_sequencer_monitor.sv
// port assertions for the measurement mode sequencer
// assumes ce_i low only while the bus is idle and no measurement runs
`timescale 1ns/10ps
`default_nettype none
`include "mms_consts.vh"
module mms_sequencer_monitor #(
  parameter [`MMS_CNT_W-1:0] MEAS_CYC = 26'h14,
  parameter [`MMS_CNT_W-1:0] TSB7_CYC = 26'h28
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic cyc_i,
  input  wire logic stb_i,
  input  wire logic ack_o,
  input  wire logic measuring_o,
  input  wire logic standby_o
);
  logic [25:0] mc_r;
  logic [25:0] sc_r;
  always @(posedge clk_i) mc_r <= (rst_i || !measuring_o) ? 26'h0 : mc_r + 26'h1;
  always @(posedge clk_i) sc_r <= (rst_i || !standby_o) ? 26'h0 : sc_r + 26'h1;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_s; cyc_i && stb_i && ce_i && !ack_o; endsequence
  sequence run_s; measuring_o [*8]; endsequence
  chk_ack_answer: assert property (req_s |=> ack_o) else $error("no ack");
  chk_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held");
  chk_reset_sleep: assert property (disable iff (1'b0) rst_i |=>
    !measuring_o && !standby_o && !ack_o) else $error("not idle after reset");
  chk_meas_length: assert property ($fell(measuring_o) |->
    mc_r == MEAS_CYC + 26'h1) else $error("bad measure length");
  chk_meas_holds: assert property ($rose(measuring_o) |-> run_s) else $error("short");
  chk_meas_cause: assert property ($rose(measuring_o) |->
    $past(standby_o) || ack_o || $past(ack_o)) else $error("start without cause");
  chk_standby_entry: assert property ($rose(standby_o) |->
    $past(measuring_o)) else $error("standby without measure");
  chk_standby_bound: assert property (sc_r <= TSB7_CYC + 26'h1) else $error("long");
  chk_one_phase: assert property (!(measuring_o && standby_o)) else $error("both");
endmodule
bind mms_sequencer mms_sequencer_monitor #(.MEAS_CYC(MEAS_CYC), .TSB7_CYC(TSB7_CYC)) u_mon (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .ack_o(ack_o), .measuring_o(measuring_o), .standby_o(standby_o));
`default_nettype wire

// file: dv/mms_sequencer_tb.sv
// self-checking bench for the measurement mode sequencer
// assumes shortened measure and standby counts
`timescale 1ns/10ps
`default_nettype none
module mms_sequencer_tb;
  typedef struct {logic w; logic [7:0] a; logic [7:0] d; logic [31:0] e;} mms_row_t;
  logic        clk_i = 1'b0;
  localparam logic [25:0] T_MEAS = 26'h14;
  localparam logic [25:0] T_SB0  = 26'h5;
  localparam logic [25:0] T_SB1  = 26'hA;
  localparam logic [25:0] T_SB2  = 26'hF;
  localparam logic [25:0] T_SB3  = 26'h14;
  localparam logic [25:0] T_SB4  = 26'h19;
  localparam logic [25:0] T_SB5  = 26'h1E;
  localparam logic [25:0] T_SB6  = 26'h23;
  localparam logic [25:0] T_SB7  = 26'h28;
  logic        rst_i = 1'b1;
  logic        ce_i  = 1'b1;
  logic [3:0]  sel_i = 4'hF;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i  = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic [31:0] q;
  logic        ack_o;
  logic        measuring_o;
  logic        standby_o;
  logic [19:0] pres;
  logic [19:0] temp;
  int          n_fail = 0;
  int          n_checks = 0;
  int          n_meas = 0;
  int          len;
  int          m;
  mms_row_t    rows [8] = '{
    '{1'b1, 8'hF5, 8'h40, 32'h0}, '{1'b0, 8'hF5, 8'h00, 32'h40},
    '{1'b0, 8'hD0, 8'h00, 32'h5A}, '{1'b1, 8'hD0, 8'hFF, 32'h0},
    '{1'b0, 8'hD0, 8'h00, 32'h5A}, '{1'b1, 8'h10, 8'h77, 32'h0},
    '{1'b0, 8'h10, 8'h00, 32'h0}, '{1'b0, 8'hF3, 8'h00, 32'h0}};
  always #50 clk_i = ~clk_i;
  always @(negedge measuring_o) if (!rst_i) n_meas++;
  mms_conv_model u_conv (.clk_i(clk_i), .measuring_i(measuring_o), .pres_o(pres), .temp_o(temp));
  mms_sequencer #(
    .MEAS_CYC(T_MEAS), .TSB0_CYC(T_SB0), .TSB1_CYC(T_SB1), .TSB2_CYC(T_SB2),
    .TSB3_CYC(T_SB3), .TSB4_CYC(T_SB4), .TSB5_CYC(T_SB5), .TSB6_CYC(T_SB6),
    .TSB7_CYC(T_SB7)
  ) uut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .raw_pres_i(pres), .raw_temp_i(temp),
    .measuring_o(measuring_o), .standby_o(standby_o));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int t;
    t = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, 24'h0, d};
    do @(posedge clk_i); while (ack_o !== 1'b1 && ++t < 50);
    if (t >= 50) n_fail++;
    q = dat_o;
    {cyc_i, stb_i} <= 2'b00;
  endtask
  // sb selects standby_o, else measuring_o; bounded so a hang still ends
  task automatic wait_for(input logic sb, input logic lvl);
    int t;
    t = 0;
    do @(posedge clk_i); while ((sb ? standby_o : measuring_o) !== lvl && ++t < 500);
    if (t >= 500) n_fail++;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    end_sim();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'hF4, 8'h00);
    chk("mode", 32'h0, q);
    foreach (rows[i]) begin
      wb(rows[i].w, rows[i].a, rows[i].d);
      chk("reg", rows[i].e, q);
    end
    sel_i <= 4'hE;
    wb(1'b1, 8'hF5, 8'hE0);
    sel_i <= 4'hF;
    wb(1'b0, 8'hF5, 8'h00);
    chk("sel masked", 32'h40, q);
    $display("registers done");
    wb(1'b1, 8'hF4, 8'h25);
    wait_for(1'b0, 1'b1);
    wait_for(1'b0, 1'b0);
    repeat (60) @(posedge clk_i);
    chk("meas count", 32'h1, n_meas);
    wb(1'b0, 8'hF4, 8'h00);
    chk("mode", 32'h24, q);
    wb(1'b0, 8'hF8, 8'h00);
    chk("pres", 32'h10000, q);
    wb(1'b1, 8'hF4, 8'h21);
    wait_for(1'b0, 1'b1);
    wait_for(1'b0, 1'b0);
    wb(1'b0, 8'hF8, 8'h00);
    chk("pres skip", 32'h80000, q);
    wb(1'b0, 8'hFC, 8'h00);
    chk("temp", 32'h20001, q);
    $display("forced done");
    wb(1'b1, 8'hF4, 8'h27);
    for (int k = 0; k < 8; k++) begin
      wait_for(1'b0, 1'b1);
      wb(1'b1, 8'hF5, 8'(k << 5));
      wait_for(1'b1, 1'b1);
      len = 1;
      do @(posedge clk_i); while (standby_o === 1'b1 && ++len < 100);
      chk("standby len", 5 * (k + 1) + 1, len);
      wb(1'b0, 8'hF8, 8'h00);
      chk("pres normal", 32'h10000 + n_meas - 1, q);
    end
    // clock enable low in standby must stretch it by the frozen cycles
    wb(1'b1, 8'hF5, 8'h00);
    wait_for(1'b0, 1'b1);
    wait_for(1'b1, 1'b1);
    ce_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    ce_i <= 1'b1;
    len = 11;
    do @(posedge clk_i); while (standby_o === 1'b1 && ++len < 100);
    chk("ce freeze", 32'd16, len);
    $display("normal done");
    wait_for(1'b1, 1'b1);
    wait_for(1'b0, 1'b1);
    wb(1'b1, 8'hF4, 8'h24);
    wb(1'b1, 8'hF4, 8'h25);
    wb(1'b0, 8'hF4, 8'h00);
    chk("mode held", 32'h27, q);
    wait_for(1'b0, 1'b0);
    m = n_meas;
    repeat (60) @(posedge clk_i);
    chk("sleep idle", m, n_meas);
    wb(1'b0, 8'hF4, 8'h00);
    chk("mode", 32'h24, q);
    wb(1'b1, 8'hF4, 8'h27);
    wait_for(1'b0, 1'b1);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'hF4, 8'h00);
    chk("mode", 32'h0, q);
    $display("pending and reset done");
    end_sim();
  end
endmodule
`default_nettype wire
